// ---- sdr_pkg.sv ----
// Package for the decimator rate and settling controller
package sdr_pkg;
	// Register byte addresses
	localparam logic [3:0] ADDR_MODE = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_COUNT = 4'h8;
	localparam logic [3:0] ADDR_CHAN = 4'hc;
	// Mode register field positions
	localparam int FW_LSB = 0;
	localparam int FW_MSB = 9;
	localparam int BIT_DUAL_NOTCH = 10;
	localparam int BIT_ZERO_LAT = 11;
	localparam int BIT_THIRD = 15;
	// Status register field positions
	localparam int BIT_SETTLED = 0;
	localparam int BIT_WORD_BAD = 1;
	localparam int BIT_THIRD_ST = 2;
	localparam int BIT_ZL_ST = 3;
	// Mode register reset value: fourth order, word 96
	localparam logic [15:0] MODE_RESET = 16'h0060;
	// Modulator clocks per unit of the filter word
	localparam int MCLK_PER_WORD = 1024;
	localparam int PERIODS_FOURTH = 4;
	localparam int PERIODS_THIRD = 3;

	typedef struct packed {
		logic third_order_select;
		logic zero_latency;
		logic dual_notch_enable;
		logic [9:0] rate_divider_word;
	} sdr_cfg_s;

	typedef enum logic [1:0] {
		SDR_IDLE,
		SDR_SETTLE,
		SDR_RUN
	} sdr_state_e;
endpackage

// ---- sdr_rate_ctrl.sv ----
// Conversion rate, settling and channel-change control for the sinc decimator
//////////////////////////////////////////////////////////////////////////////
// Operation
// - Fourth order, no zero latency: one result per 1024 times word master clocks.
// - Fourth-order settling lasts four output periods.
// - Fourth order channel change: reset filter, first result after settling, then every period.
// - Fourth order input step never stops the stream; settled data follow later.
// - Mode bit 11 enables zero latency for either order.
// - Zero latency spends full settling on every result, constant conversion time.
// - Fourth order zero latency: one result per 4 times 1024 times word clocks.
// - Zero latency aligned step gives settled results; unaligned gives one unsettled.
// - Order-select bit one picks third order, otherwise fourth order.
// - Third order: one result per 1024 times word clocks, settling three periods.
// - Third order channel change: reset filter, first result after settling, then every period.
// - Third order input step never stops the stream; settled data follow later.
// - Third order zero latency: one result per 3 times 1024 times word clocks.
// - Dual-notch bit changes notches only, never the output data rate.
// - Fourth order, word 480: 10 Hz normally, 2.5 Hz zero latency.
// - Fourth order, word 96: 50 Hz normally, 12.5 Hz zero latency.
// - After reset the fourth-order filter is selected, chop absent.
//
// Implementation choices: strobed register access and the register offsets.
module sdr_rate_ctrl #(
	parameter int WORD_W = 10
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [3:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [31:0] bus_rdata,
	input wire logic conv_enable,
	input wire logic channel_change,
	input wire logic input_step,
	output logic result_valid,
	output logic result_settled,
	output logic filter_reset,
	output logic filter_third_order,
	output logic notch_dual,
	output logic decim_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	//////////////////////////////////////////////////////////////////////////
	localparam logic [9:0] MCLK_LAST = 10'(sdr_pkg::MCLK_PER_WORD - 1);
	localparam logic [2:0] P4 = 3'(sdr_pkg::PERIODS_FOURTH);
	localparam logic [2:0] P3 = 3'(sdr_pkg::PERIODS_THIRD);

	logic [15:0] mode_reg;
	sdr_pkg::sdr_cfg_s cfg;
	sdr_pkg::sdr_state_e state_reg;
	logic [9:0] mclk_cnt_reg;
	logic [WORD_W-1:0] word_cnt_reg;
	logic [2:0] period_cnt_reg;
	logic [2:0] unsettled_reg;
	logic [7:0] chan_reg;
	logic [15:0] result_cnt_reg;
	logic [2:0] periods_needed;
	logic word_bad;
	logic period_end;
	logic result_now;
	logic step_mid;

	assign cfg.third_order_select = mode_reg[sdr_pkg::BIT_THIRD];
	assign cfg.zero_latency = mode_reg[sdr_pkg::BIT_ZERO_LAT];
	assign cfg.dual_notch_enable = mode_reg[sdr_pkg::BIT_DUAL_NOTCH];
	assign cfg.rate_divider_word = mode_reg[sdr_pkg::FW_MSB:sdr_pkg::FW_LSB];

	assign word_bad = (cfg.rate_divider_word == 10'h000);
	assign periods_needed = cfg.third_order_select ? P3 : P4;
	// One output period is 1024 times the word in master clocks
	assign period_end = (mclk_cnt_reg == MCLK_LAST) && (word_cnt_reg == WORD_W'(cfg.rate_divider_word - 10'h001));
	assign step_mid = input_step && (mclk_cnt_reg != 10'h000 || word_cnt_reg != '0);
	// Zero latency waits the whole settling per result
	assign result_now = period_end && ((state_reg == sdr_pkg::SDR_RUN && !cfg.zero_latency) ||
		(period_cnt_reg == periods_needed - 3'h1));

	//////////////////////////////////////////////////////////////////////////
	// Mode register; a config write restarts settling via the state machine
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mode_reg <= sdr_pkg::MODE_RESET;
		end else if (bus_wr && bus_addr == sdr_pkg::ADDR_MODE) begin
			mode_reg <= bus_wdata[15:0];
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			chan_reg <= 8'h00;
		end else if (bus_wr && bus_addr == sdr_pkg::ADDR_CHAN) begin
			chan_reg <= bus_wdata[7:0];
		end
	end

	// Read data valid one cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bus_rdata <= 32'h0000_0000;
		end else if (bus_rd) begin
			unique case (bus_addr)
				sdr_pkg::ADDR_MODE: bus_rdata <= {16'h0000, mode_reg};
				sdr_pkg::ADDR_STATUS: bus_rdata <= {28'h0000000, cfg.zero_latency, cfg.third_order_select,
					word_bad, result_settled};
				sdr_pkg::ADDR_COUNT: bus_rdata <= {16'h0000, result_cnt_reg};
				sdr_pkg::ADDR_CHAN: bus_rdata <= {24'h000000, chan_reg};
				default: bus_rdata <= 32'h0000_0000;
			endcase
		end else begin
			bus_rdata <= 32'h0000_0000;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Sequencer: channel change or mode write restarts settling; channel change resets the filter, a mode write does not
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= sdr_pkg::SDR_IDLE;
		end else if (!conv_enable || word_bad) begin
			state_reg <= sdr_pkg::SDR_IDLE;
		end else if (channel_change || (bus_wr && bus_addr == sdr_pkg::ADDR_MODE)) begin
			state_reg <= sdr_pkg::SDR_SETTLE;
		end else begin
			unique case (state_reg)
				sdr_pkg::SDR_IDLE: state_reg <= sdr_pkg::SDR_SETTLE;
				sdr_pkg::SDR_SETTLE: if (result_now) begin
					state_reg <= sdr_pkg::SDR_RUN;
				end
				sdr_pkg::SDR_RUN: state_reg <= sdr_pkg::SDR_RUN;
			endcase
		end
	end

	// Master clock divider, 1024 times word
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mclk_cnt_reg <= 10'h000;
			word_cnt_reg <= '0;
		end else if (state_reg == sdr_pkg::SDR_IDLE || channel_change || bus_wr && bus_addr == sdr_pkg::ADDR_MODE) begin
			mclk_cnt_reg <= 10'h000;
			word_cnt_reg <= '0;
		end else if (mclk_cnt_reg == MCLK_LAST) begin
			mclk_cnt_reg <= 10'h000;
			word_cnt_reg <= period_end ? '0 : word_cnt_reg + WORD_W'(1);
		end else begin
			mclk_cnt_reg <= mclk_cnt_reg + 10'h001;
		end
	end

	// Period counter spans the settling interval
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			period_cnt_reg <= 3'h0;
		end else if (state_reg == sdr_pkg::SDR_IDLE || channel_change || bus_wr && bus_addr == sdr_pkg::ADDR_MODE) begin
			period_cnt_reg <= 3'h0;
		end else if (period_end) begin
			period_cnt_reg <= (period_cnt_reg == periods_needed - 3'h1) ? 3'h0 : period_cnt_reg + 3'h1;
		end
	end

	// Results after a step counted as unsettled
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			unsettled_reg <= 3'h0;
		end else if (input_step && state_reg == sdr_pkg::SDR_RUN) begin
			// Zero latency: aligned only at the start of a whole conversion
			if (cfg.zero_latency) begin
				unsettled_reg <= (step_mid || period_cnt_reg != 3'h0) ? 3'h1 : 3'h0;
			end else begin
				// Result in progress counts when the step lands mid-period
				unsettled_reg <= step_mid ? periods_needed : periods_needed - 3'h1;
			end
		end else if (result_now && unsettled_reg != 3'h0) begin
			unsettled_reg <= unsettled_reg - 3'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			result_valid <= 1'b0;
			result_settled <= 1'b0;
			result_cnt_reg <= 16'h0000;
		end else begin
			result_valid <= result_now && state_reg != sdr_pkg::SDR_IDLE;
			if (result_now) begin
				result_settled <= (unsettled_reg == 3'h0);
				result_cnt_reg <= result_cnt_reg + 16'h0001;
			end
		end
	end

	// Filter controls; dual notch alters coefficients, not the rate
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			filter_reset <= 1'b1;
			filter_third_order <= 1'b0;
			notch_dual <= 1'b0;
			decim_tick <= 1'b0;
		end else begin
			filter_reset <= state_reg == sdr_pkg::SDR_IDLE || channel_change;
			filter_third_order <= cfg.third_order_select;
			notch_dual <= cfg.dual_notch_enable;
			// Tick rate follows the word only, not zero latency or order
			decim_tick <= period_end;
		end
	end
endmodule

// ---- sdr_rate_ctrl_assertions.sv ----
// Port assertions for the decimator rate controller
module sdr_chk (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [3:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [31:0] bus_rdata,
	input wire logic conv_enable,
	input wire logic channel_change,
	input wire logic result_valid,
	input wire logic filter_reset,
	input wire logic filter_third_order,
	input wire logic notch_dual,
	input wire logic decim_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////
	// Mode write left alone long enough to reach the outputs
	sequence s_mode_hold;
		bus_wr && bus_addr == sdr_pkg::ADDR_MODE ##1 !bus_wr [*2];
	endsequence
	a_valid_gap: assert property (result_valid |=> !result_valid [*8]) else $error("results too close");
	a_tick_gap: assert property (decim_tick |=> !decim_tick [*8]) else $error("period ticks too close");
	a_third_mirror: assert property (s_mode_hold |->
		filter_third_order == $past(bus_wdata[sdr_pkg::BIT_THIRD], 2)) else $error("order not applied");
	a_notch_mirror: assert property (s_mode_hold |->
		notch_dual == $past(bus_wdata[sdr_pkg::BIT_DUAL_NOTCH], 2)) else $error("notch not applied");
	a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0) else $error("stray read data");
	a_chan_reset: assert property (channel_change |=> filter_reset) else $error("no filter reset");
	a_chan_settle: assert property (channel_change |-> ##2 !result_valid [*8]) else $error("early result");
	// Idle state is registered, and the reset flag one cycle behind it
	a_idle_reset: assert property (!conv_enable [*3] |-> filter_reset) else $error("idle without reset");
endmodule
bind sdr_rate_ctrl sdr_chk sdr_chk_inst (.sys_clk, .nrst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
	.bus_rdata, .conv_enable, .channel_change, .result_valid, .filter_reset, .filter_third_order,
	.notch_dual, .decim_tick);

// ---- tb_sdr_rate_ctrl.sv ----
// Self-checking bench for the decimator rate controller
`define CHK(c, e, g) begin n_checks++; if ((g) !== (e)) begin \
	n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h", c, e, g); end end
module tb_sdr_rate_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] bus_addr = 4'h0;
	logic [31:0] bus_wdata = 32'h0;
	logic bus_wr = 1'b0, bus_rd = 1'b0, conv_enable = 1'b0, channel_change = 1'b0, input_step = 1'b0;
	logic [31:0] bus_rdata, rv;
	logic result_valid, result_settled, filter_reset, filter_third_order, notch_dual, decim_tick;
	int n_mismatch = 0, n_checks = 0, gap;
	// Only legal words, except the deliberate zero test
	// Word 1 keeps a period at 1024 clocks so the run stays short
	logic [15:0] modes [5] = '{16'h0001, 16'h0801, 16'h8001, 16'h8801, 16'h0401};
	int per [5] = '{1, 4, 1, 3, 1};
	int settle [5] = '{4, 4, 3, 3, 4};
	always #20 sys_clk = ~sys_clk;
	sdr_rate_ctrl sdr_rate_ctrl_inst (.sys_clk, .nrst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
		.conv_enable, .channel_change, .input_step, .result_valid, .result_settled, .filter_reset,
		.filter_third_order, .notch_dual, .decim_tick);
	////////////////////////////////////////
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1 d = bus_rdata;
		@(posedge sys_clk);
	endtask
	// Sampled just past the edge so registered outputs have landed
	task automatic next_res(output int n);
		n = 0;
		do begin
			@(posedge sys_clk);
			#1 n++;
		end while (result_valid !== 1'b1 && n < 20000);
	endtask
	task automatic step_chk(input int nu);
		next_res(gap);
		repeat (100) @(posedge sys_clk);
		input_step <= 1'b1;
		@(posedge sys_clk);
		input_step <= 1'b0;
		for (int k = 0; k <= nu; k++) begin
			next_res(gap);
			`CHK("settled", k == nu, result_settled)
		end
		$display("step test done");
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		rd(sdr_pkg::ADDR_MODE, rv);
		`CHK("mode reset", {16'h0, sdr_pkg::MODE_RESET}, rv)
		`CHK("order reset", 1'b0, filter_third_order)
		rd(4'h1, rv);
		`CHK("unmapped", 32'h0, rv)
		$display("reset test done");
		conv_enable <= 1'b1;
		foreach (modes[i]) begin
			wr(sdr_pkg::ADDR_MODE, {16'h0, modes[i]});
			next_res(gap);
			`CHK("first", 1'b1, gap >= settle[i] * 1024 && gap <= settle[i] * 1024 + 3)
			next_res(gap);
			`CHK("period", per[i] * 1024, gap)
			`CHK("order", modes[i][15], filter_third_order)
			`CHK("notch", modes[i][10], notch_dual)
			$display("rate test %0d done", i);
		end
		// Non-zero-latency step lands mid-period: one extra unsettled result
		step_chk(4);
		channel_change <= 1'b1;
		@(posedge sys_clk);
		channel_change <= 1'b0;
		next_res(gap);
		`CHK("chan first", 1'b1, gap >= 4096 && gap <= 4099)
		wr(sdr_pkg::ADDR_CHAN, 32'h0000_005a);
		rd(sdr_pkg::ADDR_CHAN, rv);
		`CHK("chan reg", 32'h0000_005a, rv)
		$display("channel test done");
		wr(sdr_pkg::ADDR_MODE, 32'h0801);
		step_chk(1);
		wr(sdr_pkg::ADDR_MODE, 32'h0);
		rd(sdr_pkg::ADDR_STATUS, rv);
		`CHK("word zero", 1'b1, rv[sdr_pkg::BIT_WORD_BAD])
		$display("word test done");
		give_verdict();
	end
	initial begin
		repeat (90000) @(posedge sys_clk);
		n_mismatch++;
		give_verdict();
	end
endmodule
